/* File: rtl/sramc_regs.svh */
`ifndef SRAMC_REGS_SVH
`define SRAMC_REGS_SVH

// Timing figures in ns, slowest speed grade
`define SRAMC_CLK_NS 40
`define SRAMC_T_RC_NS 450
`define SRAMC_T_A_NS 450
`define SRAMC_T_W_NS 200
`define SRAMC_T_DW_NS 200
`define SRAMC_T_WR_NS 0
`define SRAMC_T_WC_NS 450
`define SRAMC_T_OTW_NS 100

// Least times round up
`define SRAMC_CYC_UP(ns) (((ns) + `SRAMC_CLK_NS - 1) / `SRAMC_CLK_NS)
`define SRAMC_MIN1(n) (((n) < 1) ? 1 : (n))

// Pin data reaches the state machine four edges after it settles
`define SRAMC_SYNC_CYC 4

`define SRAMC_ADDR_W 10
`define SRAMC_DATA_W 4
`define SRAMC_DEPTH 1024

`endif

/* File: rtl/sramc_pkg.sv */
package sramc_pkg;
    typedef enum logic [2:0] {
        SR_IDLE,
        SR_RD_ACCESS,
        SR_WR_SETUP,
        SR_WR_PULSE,
        SR_WR_RELEASE,
        SR_RECOVER
    } sramc_state_t;
endpackage

/* File: rtl/sramc_pin_sync.sv */
`timescale 1ns/1ns
`include "sramc_regs.svh"

module sramc_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // Change accepted only once second and third stages agree
    always_comb begin
        q_nxt = q_r;
        if (s2_r == s3_r) begin
            q_nxt = s3_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign dout = q_r;
endmodule

/* File: rtl/sramc_ctrl.sv */
`timescale 1ns/1ns
`include "sramc_regs.svh"

module sramc_ctrl #(
    parameter int ADDR_W = `SRAMC_ADDR_W,
    parameter int DATA_W = `SRAMC_DATA_W,
    parameter int T_RD_NS = `SRAMC_T_A_NS,
    parameter int T_W_NS = `SRAMC_T_W_NS,
    parameter int T_DW_NS = `SRAMC_T_DW_NS,
    parameter int T_WR_NS = `SRAMC_T_WR_NS,
    parameter int T_REC_NS = `SRAMC_T_OTW_NS
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_RDATA,
    output logic [ADDR_W-1:0] MEM_ADDR,
    output logic MEM_CS_N,
    output logic MEM_WE_N,
    output logic MEM_OUTPUT_DISABLE,
    output logic [DATA_W-1:0] MEM_DQ_O,
    output logic MEM_DQ_OE,
    input wire logic [DATA_W-1:0] MEM_DQ_I
);
    // Counts round up so each counted minimum time is met; back-to-back writes start 440 ns apart, under SRAMC_T_WC_NS
    localparam int SYNC_CYC = `SRAMC_SYNC_CYC;
    localparam int RD_CYC = `SRAMC_MIN1(`SRAMC_CYC_UP(T_RD_NS)) + SYNC_CYC;
    localparam int W_CYC = `SRAMC_MIN1(`SRAMC_CYC_UP(T_W_NS));
    localparam int DW_CYC = `SRAMC_MIN1(`SRAMC_CYC_UP(T_DW_NS));
    localparam int PULSE_CYC = (W_CYC > DW_CYC) ? W_CYC : DW_CYC;
    localparam int WR_CYC = `SRAMC_MIN1(`SRAMC_CYC_UP(T_WR_NS));
    localparam int REC_CYC = `SRAMC_MIN1(`SRAMC_CYC_UP(T_REC_NS));
    localparam int CNT_W = 8;

    // Counter is fixed at eight bits, long timing overrides must fit
    if (ADDR_W != `SRAMC_ADDR_W || DATA_W != `SRAMC_DATA_W) begin : g_bad_geometry
        $error("Array geometry must be 1024 x 4");
    end
    if (RD_CYC >= (1 << CNT_W)) begin : g_bad_read_time
        $error("Read count exceeds counter width");
    end
    if (PULSE_CYC >= (1 << CNT_W)) begin : g_bad_pulse_time
        $error("Pulse count exceeds counter width");
    end
    if (WR_CYC >= (1 << CNT_W)) begin : g_bad_release_time
        $error("Release count exceeds counter width");
    end
    if (REC_CYC >= (1 << CNT_W)) begin : g_bad_recover_time
        $error("Recovery count exceeds counter width");
    end

    sramc_pkg::sramc_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic ready_r, ready_nxt;
    logic rsp_r, rsp_nxt;
    logic cs_n_r, cs_n_nxt;
    logic we_n_r, we_n_nxt;
    logic od_r, od_nxt;
    logic oe_r, oe_nxt;
    logic [DATA_W-1:0] dq_sync;

    sramc_pin_sync #(
        .WIDTH(DATA_W)
    ) u_dq_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .din(MEM_DQ_I),
        .dout(dq_sync)
    );

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        ready_nxt = ready_r;
        rsp_nxt = 1'b0;
        cs_n_nxt = cs_n_r;
        we_n_nxt = we_n_r;
        od_nxt = od_r;
        oe_nxt = oe_r;
        unique case (state_r)
            sramc_pkg::SR_IDLE: begin
                if (REQ_VALID && ready_r) begin
                    ready_nxt = 1'b0;
                    addr_nxt = REQ_ADDR;
                    wdata_nxt = REQ_WDATA;
                    if (REQ_WRITE) begin
                        // Address settles one cycle before the window opens
                        state_nxt = sramc_pkg::SR_WR_SETUP;
                        od_nxt = 1'b1;
                    end else begin
                        cs_n_nxt = 1'b0;
                        we_n_nxt = 1'b1;
                        od_nxt = 1'b0;
                        cnt_nxt = CNT_W'(RD_CYC - 1);
                        state_nxt = sramc_pkg::SR_RD_ACCESS;
                    end
                end
            end
            sramc_pkg::SR_RD_ACCESS: begin
                // Extra cycles cover the input synchroniser latency
                // Three stages plus the agreement register: four edges
                if (cnt_r == '0) begin
                    rdata_nxt = dq_sync;
                    rsp_nxt = 1'b1;
                    cs_n_nxt = 1'b1;
                    od_nxt = 1'b1;
                    cnt_nxt = CNT_W'(REC_CYC - 1);
                    state_nxt = sramc_pkg::SR_RECOVER;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            sramc_pkg::SR_WR_SETUP: begin
                // Select and write enable fall together, data drive switches on at the same edge
                cs_n_nxt = 1'b0;
                we_n_nxt = 1'b0;
                oe_nxt = 1'b1;
                cnt_nxt = CNT_W'(PULSE_CYC - 1);
                state_nxt = sramc_pkg::SR_WR_PULSE;
            end
            sramc_pkg::SR_WR_PULSE: begin
                // Address and data held fixed for the whole pulse
                if (cnt_r == '0) begin
                    we_n_nxt = 1'b1;
                    cs_n_nxt = 1'b1;
                    cnt_nxt = CNT_W'(WR_CYC - 1);
                    state_nxt = sramc_pkg::SR_WR_RELEASE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            sramc_pkg::SR_WR_RELEASE: begin
                // Address still held after the window closes
                if (cnt_r == '0) begin
                    oe_nxt = 1'b0;
                    cnt_nxt = CNT_W'(REC_CYC - 1);
                    state_nxt = sramc_pkg::SR_RECOVER;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            sramc_pkg::SR_RECOVER: begin
                // Lets the device release the bus before the next cycle
                if (cnt_r == '0) begin
                    ready_nxt = 1'b1;
                    state_nxt = sramc_pkg::SR_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                // Illegal code: drop every strobe and release the bus
                state_nxt = sramc_pkg::SR_IDLE;
                cs_n_nxt = 1'b1;
                we_n_nxt = 1'b1;
                od_nxt = 1'b1;
                oe_nxt = 1'b0;
                ready_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r <= sramc_pkg::SR_IDLE;
            cnt_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            ready_r <= 1'b1;
            rsp_r <= 1'b0;
            cs_n_r <= 1'b1;
            we_n_r <= 1'b1;
            od_r <= 1'b1;
            oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= ready_nxt;
            rsp_r <= rsp_nxt;
            cs_n_r <= cs_n_nxt;
            we_n_r <= we_n_nxt;
            od_r <= od_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign REQ_READY = ready_r;
    assign RSP_VALID = rsp_r;
    assign RSP_RDATA = rdata_r;
    assign MEM_ADDR = addr_r;
    assign MEM_CS_N = cs_n_r;
    assign MEM_WE_N = we_n_r;
    assign MEM_OUTPUT_DISABLE = od_r;
    assign MEM_DQ_O = wdata_r;
    assign MEM_DQ_OE = oe_r;
endmodule

/* File: bench/sramc_sva.sv */
`timescale 1ns/1ns
module sramc_sva #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 4
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [DATA_W-1:0] REQ_WDATA,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic [DATA_W-1:0] RSP_RDATA,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic MEM_CS_N,
    input wire logic MEM_WE_N,
    input wire logic MEM_OUTPUT_DISABLE,
    input wire logic [DATA_W-1:0] MEM_DQ_O,
    input wire logic MEM_DQ_OE,
    input wire logic [DATA_W-1:0] MEM_DQ_I
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_read_we_high: assert property (!MEM_OUTPUT_DISABLE |-> MEM_WE_N)
        else $error("write enable low while outputs on");
    a_joint_open: assert property ($fell(MEM_WE_N) |-> $fell(MEM_CS_N))
        else $error("window edges apart");
    a_pulse_len: assert property ($fell(MEM_WE_N) |-> !MEM_WE_N[*5] ##1 MEM_WE_N)
        else $error("pulse length wrong");
    a_addr_hold: assert property (!MEM_WE_N || $rose(MEM_WE_N) |-> $stable(MEM_ADDR))
        else $error("address moved in window");
    a_data_hold: assert property (!MEM_WE_N |=> $stable(MEM_DQ_O) && MEM_DQ_OE)
        else $error("data moved in window");
    a_od_write: assert property (!MEM_WE_N |-> MEM_OUTPUT_DISABLE && MEM_DQ_OE)
        else $error("outputs on during write");
    a_desel_we: assert property (MEM_CS_N |-> MEM_WE_N)
        else $error("write enable low while deselected");
    a_write_done: assert property (REQ_VALID && REQ_READY && REQ_WRITE |=> !REQ_READY ##10 REQ_READY)
        else $error("write length wrong");
    a_read_rsp: assert property (REQ_VALID && REQ_READY && !REQ_WRITE |-> ##17 RSP_VALID)
        else $error("read answer late");
    c_write: cover property ($fell(MEM_WE_N));
    c_read: cover property (RSP_VALID);
    c_od_low: cover property ($fell(MEM_OUTPUT_DISABLE));
endmodule

/* File: bench/sramc_mem_model.sv */
`timescale 1ns/1ns
module sramc_mem_model #(
    parameter int ACC_NS = 450
) (
    input wire logic [9:0] addr,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic od,
    input wire logic [3:0] dq,
    output logic [3:0] q,
    output logic q_oe
);
    logic [3:0] mem_r [1024];
    wire win = !cs_n && !we_n;
    // Decode is combinational, so no address setup is needed
    always @(negedge win) mem_r[addr] = dq;
    // Slow access so the answer arrives late in the read
    assign #ACC_NS q = mem_r[addr];
    assign q_oe = !cs_n && we_n && !od;
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [9:0] req_addr = 10'h000;
    logic [3:0] req_wdata = 4'h0;
    logic req_ready, rsp_valid, cs_n, we_n, od, dq_oe, q_oe;
    logic [3:0] rsp_rdata, dq_o, q;
    logic [3:0] dq_last = 4'h0;
    logic [9:0] mem_addr;
    // Released bus shows the inverse of its last level
    wire [3:0] dq = dq_oe ? dq_o : (q_oe ? q : ~dq_last);
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    always @(posedge clk) dq_last <= dq;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count = err_count + 1;
            summarize();
        end
    end
    sramc_ctrl dut_u (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(req_ready),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .MEM_ADDR(mem_addr), .MEM_CS_N(cs_n),
        .MEM_WE_N(we_n), .MEM_OUTPUT_DISABLE(od), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe),
        .MEM_DQ_I(dq));
    sramc_mem_model mem_u (.addr(mem_addr), .cs_n(cs_n), .we_n(we_n), .od(od), .dq(dq),
        .q(q), .q_oe(q_oe));
    task automatic check(string what, logic [3:0] exp, logic [3:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic request(logic w, logic [9:0] a, logic [3:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
    endtask
    task automatic read_check(logic [9:0] a, logic [3:0] exp);
        int n;
        n = 0;
        request(1'b0, a, 4'h0);
        while (rsp_valid !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("read valid", 4'h1, {3'h0, rsp_valid});
        check("read data", exp, rsp_rdata);
    endtask
    // Every data pattern, top address included
    task automatic t_patterns();
        for (int i = 0; i < 16; i++) request(1'b1, {i[3:0], 6'h3f}, ~i[3:0]);
        for (int i = 0; i < 16; i++) read_check({i[3:0], 6'h3f}, ~i[3:0]);
    endtask
    // Back-to-back writes, last wins, neighbour and repeat reads intact
    task automatic t_overwrite();
        request(1'b1, 10'h000, 4'h3);
        request(1'b1, 10'h001, 4'h9);
        request(1'b1, 10'h000, 4'hc);
        read_check(10'h000, 4'hc);
        read_check(10'h001, 4'h9);
        read_check(10'h001, 4'h9);
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("idle pins", 4'hf, {req_ready, cs_n, we_n, od});
        check("dq drive", 4'h0, {3'h0, dq_oe});
        t_patterns();
        t_overwrite();
        summarize();
    end
endmodule
bind sramc_ctrl sramc_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (.CLK, .RST_N,
    .REQ_VALID, .REQ_WRITE, .REQ_ADDR, .REQ_WDATA, .REQ_READY, .RSP_VALID, .RSP_RDATA,
    .MEM_ADDR, .MEM_CS_N, .MEM_WE_N, .MEM_OUTPUT_DISABLE, .MEM_DQ_O, .MEM_DQ_OE, .MEM_DQ_I);
